// ---- logic/iea_indirect_access.sv ----
// Indirect access window into the extended register space
// How it works
// RQ1 - Extended registers above 0x1F are reached only via control and window registers.
// RQ2 - Function 00: window write loads the extended pointer.
// RQ3 - Controller loads the pointer before any extended data access.
// RQ4 - Function 01: window access hits pointed register, pointer unchanged.
// RQ5 - Function 10: window access hits pointed register, then pointer increments.
// RQ6 - Function 11: pointer increments after writes only, not after reads.
// RQ7 - Only device select 11111 honoured; other values make window accesses ignored.
// RQ8 - Controller programs 0x1F into the device select field first.
// RQ9 - Control bits 13:5 ignore writes and read zero.
// RQ10 - Window reads pointer in function 00, else selected extended data.
// RQ11 - Gigabit capability bits 15 and 14 read as zero.
// RQ12 - Gigabit capability bits 13 and 12 read as one.
// RQ13 - Gigabit capability bits 11:0 ignore writes and read zero.
// RQ14 - Pointer post-increment wraps from maximum back to zero.
`timescale 1ns/1ns
module iea_indirect_access (
   input wire logic sys_clk, // 100 MHz clock
   input wire logic arst_n, // Async reset, active low
   input wire logic [4:0] mgmtAddr, // Direct register address
   input wire logic mgmtWr, // Direct write strobe
   input wire logic mgmtRd, // Direct read strobe
   input wire logic [15:0] mgmtWdata, // Direct write data
   output logic [15:0] mgmtRdata, // Read data, registered
   output logic mgmtRdValid, // Read data valid pulse
   output logic mgmtHit, // Hit pulse, access in the previous cycle hit this block
   output logic [15:0] extPtr, // Extended pointer, read lookup address
   input wire logic [15:0] extRdata, // Extended data at extPtr
   output logic [15:0] extAccAddr, // Address of extended access
   output logic extWr, // Extended write pulse
   output logic [15:0] extWdata, // Extended write data
   output logic extRd // Extended read pulse, for read side effects
);
   logic [1:0] func_q;
   logic [4:0] devSel_q;
   logic [15:0] ptr_q;
   logic [15:0] ptr_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic rdValid_q;
   logic hit_q;
   logic [15:0] accAddr_q;
   logic extWr_q;
   logic [15:0] extWdata_q;
   logic extRd_q;

   wire logic selCtrl;
   wire logic selWin;
   wire logic selCap;
   wire logic devOk;
   wire logic winWr;
   wire logic winRd;
   wire logic dataMode;
   wire logic [15:0] ctrlRead;
   wire logic [15:0] winRead;

   // Direct space holds only 5-bit addresses, extended space has no direct path
   assign selCtrl = (mgmtAddr == iea_pkg::OFS_ACCESS_CONTROL); // see RQ1
   assign selWin = (mgmtAddr == iea_pkg::OFS_ADDR_DATA_WINDOW); // see RQ1
   assign selCap = (mgmtAddr == iea_pkg::OFS_GIGABIT_CAP_STATUS);
   assign devOk = (devSel_q == iea_pkg::DEVSEL_VENDOR); // see RQ7 see RQ8
   assign winWr = mgmtWr && selWin && devOk; // see RQ7
   assign winRd = mgmtRd && selWin && devOk; // see RQ7
   assign dataMode = (func_q != iea_pkg::FUNC_ADDRESS);
   assign ctrlRead = {func_q, 9'h000, devSel_q}; // see RQ9
   // Ignored device select reads back zero, no extended side effect
   assign winRead = !devOk ? 16'h0000 : dataMode ? extRdata : ptr_q; // see RQ10 see RQ3
   assign rdata_d = selCtrl ? ctrlRead :
                    selWin ? winRead :
                    selCap ? iea_pkg::GIGABIT_CAP_VALUE : // see RQ11 see RQ12 see RQ13
                    16'h0000;

   iea_ptr_next iea_ptr_next_i (
      .ptrCur(ptr_q),
      .func(func_q),
      .winWr(winWr),
      .winRd(winRd),
      .wrData(mgmtWdata),
      .ptrNext(ptr_d)
   );

   // Only function and device select are stored; middle bits are dropped
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         func_q <= iea_pkg::FUNC_RESET;
         devSel_q <= iea_pkg::DEVSEL_RESET;
      end else if (mgmtWr && selCtrl) begin
         func_q <= mgmtWdata[iea_pkg::FUNC_HI:iea_pkg::FUNC_LO];
         devSel_q <= mgmtWdata[iea_pkg::DEVSEL_HI:iea_pkg::DEVSEL_LO]; // see RQ9
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ptr_q <= iea_pkg::PTR_RESET;
      end else begin
         ptr_q <= ptr_d; // see RQ2 see RQ4 see RQ5 see RQ6 see RQ14
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 16'h0000;
         rdValid_q <= 1'b0;
         hit_q <= 1'b0;
      end else begin
         rdValid_q <= mgmtRd;
         hit_q <= (mgmtRd || mgmtWr) && (selCtrl || selWin || selCap);
         if (mgmtRd) begin
            rdata_q <= rdata_d;
         end
      end
   end

   // Access address captured before the pointer moves
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         accAddr_q <= 16'h0000;
         extWr_q <= 1'b0;
         extWdata_q <= 16'h0000;
         extRd_q <= 1'b0;
      end else begin
         extWr_q <= winWr && dataMode; // see RQ4
         extRd_q <= winRd && dataMode; // see RQ4
         if ((winWr || winRd) && dataMode) begin
            accAddr_q <= ptr_q;
            extWdata_q <= mgmtWdata;
         end
      end
   end

   assign mgmtRdata = rdata_q;
   assign mgmtRdValid = rdValid_q;
   assign mgmtHit = hit_q;
   assign extPtr = ptr_q;
   assign extAccAddr = accAddr_q;
   assign extWr = extWr_q;
   assign extWdata = extWdata_q;
   assign extRd = extRd_q;
endmodule : iea_indirect_access

// ---- logic/iea_pkg.sv ----
// Constants for the indirect extended register access block
package iea_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam logic [4:0] OFS_ACCESS_CONTROL = 5'h0D;
   localparam logic [4:0] OFS_ADDR_DATA_WINDOW = 5'h0E;
   localparam logic [4:0] OFS_GIGABIT_CAP_STATUS = 5'h0F;
   localparam logic [15:0] DIRECT_SPACE_TOP = 16'h001F;
   localparam int FUNC_HI = 15;
   localparam int FUNC_LO = 14;
   localparam int DEVSEL_HI = 4;
   localparam int DEVSEL_LO = 0;
   localparam logic [1:0] FUNC_RESET = 2'h0;
   localparam logic [4:0] DEVSEL_RESET = 5'h00;
   localparam logic [4:0] DEVSEL_VENDOR = 5'h1F;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [15:0] PTR_STEP = 16'h0001;
   // 1000BASE-X FD/HD zero, 1000BASE-T FD/HD one, low field zero
   localparam logic [15:0] GIGABIT_CAP_VALUE = 16'h3000;
   typedef enum logic [1:0] {
      FUNC_ADDRESS = 2'h0,
      FUNC_DATA_NOINC = 2'h1,
      FUNC_DATA_INC_RW = 2'h2,
      FUNC_DATA_INC_WR = 2'h3
   } iea_func_e;
endpackage : iea_pkg

// ---- logic/iea_ptr_next.sv ----
// Next value of the extended register pointer
`timescale 1ns/1ns
module iea_ptr_next (
   input wire logic [15:0] ptrCur, // Present pointer
   input wire logic [1:0] func, // Access function field
   input wire logic winWr, // Accepted window write
   input wire logic winRd, // Accepted window read
   input wire logic [15:0] wrData, // Window write data
   output logic [15:0] ptrNext // Pointer after this cycle
);
   wire logic isAddr;
   wire logic incOnRd;
   wire logic incOnWr;
   wire logic doInc;
   assign isAddr = (func == iea_pkg::FUNC_ADDRESS);
   assign incOnRd = (func == iea_pkg::FUNC_DATA_INC_RW); // see RQ5
   assign incOnWr = (func == iea_pkg::FUNC_DATA_INC_RW) || (func == iea_pkg::FUNC_DATA_INC_WR); // see RQ5 see RQ6
   assign doInc = (winWr && incOnWr) || (winRd && incOnRd);
   // Plain 16-bit add drops the carry, so the pointer wraps to zero
   assign ptrNext = (winWr && isAddr) ? wrData : // see RQ2
                    doInc ? ptrCur + iea_pkg::PTR_STEP : // see RQ14
                    ptrCur; // see RQ4
endmodule : iea_ptr_next

// ---- sim/iea_indirect_access_sva.sv ----
// Port assertions for the indirect access block
`timescale 1ns/1ns
module iea_indirect_access_sva (
   input wire logic sys_clk, // Clock
   input wire logic arst_n, // Reset
   input wire logic [4:0] mgmtAddr, // Address
   input wire logic mgmtWr, // Write
   input wire logic mgmtRd, // Read
   input wire logic [15:0] mgmtWdata, // Wdata
   input wire logic [15:0] mgmtRdata, // Rdata
   input wire logic [15:0] extPtr, // Pointer
   input wire logic mgmtRdValid, // Read valid
   input wire logic mgmtHit, // Hit flag
   input wire logic [15:0] extAccAddr, // Extended address
   input wire logic extWr, // Extended write
   input wire logic [15:0] extWdata, // Extended write data
   input wire logic extRd // Extended read
);
   logic [6:0] cfgQ;
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n) cfgQ <= 7'h00;
      else if (mgmtWr && mgmtAddr == 5'h0D) cfgQ <= {mgmtWdata[15:14], mgmtWdata[4:0]};
   wire logic win = (mgmtWr || mgmtRd) && mgmtAddr == 5'h0E, ok = win && cfgQ[4:0] == 5'h1F;
   wire logic hitNow = (mgmtWr || mgmtRd) && (mgmtAddr == 5'h0D || mgmtAddr == 5'h0E || mgmtAddr == 5'h0F);
   wire logic extWrNow = mgmtWr && ok && cfgQ[6:5] != 2'h0;
   wire logic extRdNow = mgmtRd && ok && cfgQ[6:5] != 2'h0;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   cap_val_a: assert property (mgmtRd && mgmtAddr == 5'h0F |=> mgmtRdata == 16'h3000) else $error("cap");
   rd_valid_a: assert property (mgmtRdValid == $past(mgmtRd)) else $error("rdvalid");
   hit_flag_a: assert property (mgmtHit == $past(hitNow)) else $error("hit");
   ext_wr_a: assert property (extWr == $past(extWrNow)) else $error("extwr");
   ext_data_a: assert property (extWrNow |=> extWdata == $past(mgmtWdata) && extAccAddr == $past(extPtr)) else $error("extdata");
   ext_rd_a: assert property (extRd == $past(extRdNow)) else $error("extrd");
   rd_gate_a: assert property (mgmtRd && win && !ok |=> mgmtRdata == 16'h0000) else $error("rdgate");
   ctl_rsvd_a: assert property (mgmtRd && mgmtAddr == 5'h0D |=> mgmtRdata[13:5] == 9'h000) else $error("ctl");
   ptr_load_a: assert property (mgmtWr && ok && cfgQ[6:5] == 2'h0 |=> extPtr == $past(mgmtWdata)) else $error("load");
   win_addr_a: assert property (mgmtRd && ok && cfgQ[6:5] == 2'h0 |=> mgmtRdata == $past(extPtr)) else $error("win");
   ptr_hold_a: assert property (ok && cfgQ[6:5] == 2'h1 |=> $stable(extPtr)) else $error("hold");
   ptr_inc_a: assert property (ok && cfgQ[6:5] == 2'h2 |=> extPtr == $past(extPtr) + 16'h0001) else $error("inc");
   wr_inc_a: assert property (ok && cfgQ[6:5] == 2'h3 |=> extPtr == $past(extPtr) + {15'h0, $past(mgmtWr)}) else $error("wr");
   devsel_gate_a: assert property (win && !ok |=> $stable(extPtr)) else $error("devsel");
   cover property (win && !ok);
   cover property (ok && cfgQ[6:5] == 2'h2);
   cover property (mgmtWr && ok && cfgQ[6:5] == 2'h3);
endmodule : iea_indirect_access_sva
bind iea_indirect_access iea_indirect_access_sva iea_indirect_access_sva_i (.*);

// ---- sim/iea_ext_space.sv ----
// Extended register model; keeps only the last write to stay small
`timescale 1ns/1ns
module iea_ext_space (
   input wire logic sys_clk, // Clock
   input wire logic [15:0] extPtr, // Read address
   output logic [15:0] extRdata, // Read data
   input wire logic [15:0] extAccAddr, // Write address
   input wire logic extWr, // Write pulse
   input wire logic [15:0] extWdata // Write data
);
   logic [15:0] lastA = 16'hFFFF, lastD = 16'hA00F;
   assign extRdata = extPtr == lastA ? lastD : 16'hA000 | extPtr;
   always @(posedge sys_clk) if (extWr) {lastA, lastD} <= {extAccAddr, extWdata};
endmodule : iea_ext_space

// ---- sim/iea_indirect_access_bench.sv ----
// Self-checking bench for the indirect access block
`timescale 1ns/1ns
module iea_indirect_access_bench;
   logic sys_clk = 1'h0, arst_n = 1'h0, mgmtWr = 1'h0, mgmtRd = 1'h0, mgmtRdValid, mgmtHit, extWr, extRd;
   logic [4:0] mgmtAddr = 5'h00;
   logic [15:0] mgmtWdata = 16'h0000, mgmtRdata, extPtr, extRdata, extAccAddr, extWdata;
   int bad_count = 0, checks = 0;
   always #5 sys_clk = ~sys_clk;
   iea_indirect_access iea_indirect_access_i (.*);
   iea_ext_space iea_ext_space_i (.*);
   task chk(input logic [15:0] s, e);
      checks++;
      if (s !== e) bad_count++;
      if (s !== e) $display("CHECK FAILED %0t read %h want %h", $time, s, e);
   endtask : chk
   task op(input logic w, input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk) #1 {mgmtWr, mgmtRd, mgmtAddr, mgmtWdata} = {w, !w, a, d};
      @(posedge sys_clk) #1 {mgmtWr, mgmtRd} = 2'h0;
      if (!w) chk(mgmtRdata, d);
   endtask : op
   task stop_test(input int late);
      bad_count += late;
      if (bad_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   initial #5000 stop_test(1);
   initial begin
      #51 arst_n = 1'h1;
      op(1'h0, 5'h0F, 16'h3000);
      op(1'h1, 5'h0D, 16'hFFE5);
      op(1'h0, 5'h0D, 16'hC005);
      op(1'h1, 5'h0E, 16'h1234);
      op(1'h1, 5'h0D, 16'h001F);
      op(1'h0, 5'h0E, 16'h0000);
      op(1'h1, 5'h0E, 16'hFFFF);
      op(1'h1, 5'h0D, 16'h801F);
      op(1'h0, 5'h0E, 16'hA00F);
      op(1'h0, 5'h0E, 16'hA000);
      op(1'h1, 5'h0D, 16'h401F);
      op(1'h1, 5'h0E, 16'h7777);
      op(1'h0, 5'h0E, 16'h7777);
      op(1'h1, 5'h0D, 16'hC01F);
      op(1'h1, 5'h0E, 16'h5555);
      op(1'h0, 5'h0E, 16'hA002);
      op(1'h0, 5'h0E, 16'hA002);
      op(1'h1, 5'h0F, 16'hFFFF);
      op(1'h0, 5'h0F, 16'h3000);
      op(1'h0, 5'h10, 16'h0000);
      arst_n = 1'h0;
      #20 arst_n = 1'h1;
      op(1'h0, 5'h0D, 16'h0000);
      op(1'h1, 5'h0E, 16'h4321);
      op(1'h0, 5'h0E, 16'h0000);
      stop_test(0);
   end
endmodule : iea_indirect_access_bench
